/* File: core/sbh_pkg.sv */
// Constants shared by both ends of the special block link.
// Assumes one 50 MHz clock and whole blocks passed as word streams.
package sbh_pkg;
	localparam int WORD_W = 16;
	localparam int BLK_WORDS = 250;
	localparam int IDX_W = 8;
	localparam logic [15:0] ID_MAP_P1 = 16'h1B58;
	localparam logic [15:0] ID_MAP_P2 = 16'h1BBC;
	localparam logic [15:0] ID_SET_TIME = 16'h26F4;
	localparam logic [15:0] ID_GET_TIME = 16'h26F5;
	localparam logic [15:0] ID_WARM = 16'h270E;
	localparam logic [15:0] ID_COLD = 16'h270F;
	localparam int MAP_ENTRIES = 50;
	localparam int MAP_ENTRY_WORDS = 4;
	localparam int MAP_FIRST_WORD = 1;
	localparam int REPLY_ID_WORD = 249;
	localparam int REPLY_NEXT_WORD = 1;
	localparam int TIME_FIRST_WORD = 2;
	localparam int MS_WORD = 8;
	localparam int CYCLES_PER_MS = 50000;
	localparam logic [15:0] MONTH_MAX = 16'h000C;
	localparam logic [15:0] DAY_MAX = 16'h001F;
	localparam logic [15:0] HOUR_MAX = 16'h0017;
	localparam logic [15:0] MINSEC_MAX = 16'h003B;
	localparam logic [15:0] MS_MAX = 16'h03E7;
	localparam logic [15:0] YEAR_RESET = 16'h07D0;
endpackage : sbh_pkg

/* File: core/sbh_link_if.sv */
// Block transfer link between host processor and module.
// Assumes both ends share core_clk_i; one word per valid cycle.
`timescale 1ns/1ps
`default_nettype none
interface sbh_link_if;
	logic wr_valid;
	logic [7:0] wr_idx;
	logic [15:0] wr_data;
	logic wr_last;
	logic rd_valid;
	logic [7:0] rd_idx;
	logic [15:0] rd_data;
	logic rd_last;
	modport module_end (input wr_valid, wr_idx, wr_data, wr_last,
		output rd_valid, rd_idx, rd_data, rd_last);
	modport host_end (output wr_valid, wr_idx, wr_data, wr_last,
		input rd_valid, rd_idx, rd_data, rd_last);
endinterface : sbh_link_if
`default_nettype wire

/* File: core/sbh_module_end.sv */
// Module end: decodes special write blocks, keeps the clock and file maps.
// Assumes write blocks arrive as words 0..249 with wr_last on word 249.
`timescale 1ns/1ps
`default_nettype none
module sbh_module_end #(
	parameter int MS_CYCLES = sbh_pkg::CYCLES_PER_MS
) (
	input wire logic core_clk_i, // 50 MHz clock
	input wire logic reset_n_i, // async reset, active low
	sbh_link_if.module_end link, // block link
	input wire logic [15:0] next_block_i, // next write block requested
	input wire logic [5:0] map_sel_i, // map entry to look up
	input wire logic map_port_i, // port of map lookup
	output logic [63:0] map_entry_o, // selected map entry, four words
	output logic [15:0] year_o, // clock year
	output logic [15:0] month_o, // clock month
	output logic [15:0] day_o, // clock day
	output logic [15:0] hour_o, // clock hour
	output logic [15:0] minute_o, // clock minute
	output logic [15:0] second_o, // clock second
	output logic cold_boot_o, // hardware reset request pulse
	output logic warm_boot_o // config reload pulse
);
	typedef enum logic [1:0] {
		SBH_IDLE = 2'b00,
		SBH_RECV = 2'b01,
		SBH_REPLY = 2'b10
	} sbh_state_e;
	sbh_state_e state_reg;
	logic [15:0] id_reg;
	logic [15:0] fld_reg [1:6];
	logic [63:0] map_reg [0:99];
	logic [15:0] tm_reg [0:5];
	logic [15:0] snap_reg [0:6];
	logic [15:0] ms_reg;
	logic [31:0] tick_reg;
	logic [7:0] ridx_reg;
	logic rd_valid_reg;
	logic [15:0] rd_data_reg;
	logic [7:0] rd_idx_reg;
	logic rd_last_reg;
	logic cold_reg;
	logic warm_reg;
	logic [63:0] map_out_reg;

	wire is_map = (id_reg == sbh_pkg::ID_MAP_P1) || (id_reg == sbh_pkg::ID_MAP_P2);
	wire map_port = (id_reg == sbh_pkg::ID_MAP_P2);
	wire [7:0] map_off = link.wr_idx - 8'(sbh_pkg::MAP_FIRST_WORD);
	wire [5:0] map_ent = 6'(map_off >> 2);
	// Port 2 entries sit above the port 1 entries in one table
	wire [6:0] map_wslot = map_port ? 7'(map_ent) + 7'(sbh_pkg::MAP_ENTRIES) : 7'(map_ent);
	wire [5:0] map_lane = {map_off[1:0], 4'h0};
	// Out-of-range selects read as an empty binding, never past the table
	wire map_sel_ok = map_sel_i < 6'(sbh_pkg::MAP_ENTRIES);
	wire [6:0] map_rslot = map_port_i ? 7'(map_sel_i) + 7'(sbh_pkg::MAP_ENTRIES) : 7'(map_sel_i);
	wire map_wr = link.wr_valid && state_reg == SBH_RECV && is_map
		&& link.wr_idx >= 8'(sbh_pkg::MAP_FIRST_WORD)
		&& map_ent < 6'(sbh_pkg::MAP_ENTRIES);
	wire set_ok = (fld_reg[2] >= 16'h0001) && (fld_reg[2] <= sbh_pkg::MONTH_MAX)
		&& (fld_reg[3] >= 16'h0001) && (fld_reg[3] <= sbh_pkg::DAY_MAX)
		&& (fld_reg[4] <= sbh_pkg::HOUR_MAX) && (fld_reg[5] <= sbh_pkg::MINSEC_MAX)
		&& (fld_reg[6] <= sbh_pkg::MINSEC_MAX);
	wire blk_end = link.wr_valid && link.wr_last && state_reg == SBH_RECV;
	wire do_set = blk_end && id_reg == sbh_pkg::ID_SET_TIME && set_ok;
	wire do_get = blk_end && id_reg == sbh_pkg::ID_GET_TIME;
	wire ms_wrap = tick_reg == 32'(MS_CYCLES - 1);
	wire sec_wrap = ms_wrap && ms_reg == sbh_pkg::MS_MAX;
	// Clock only rolls through seconds to hours; day rollover left to host resync
	wire min_wrap = sec_wrap && tm_reg[5] == sbh_pkg::MINSEC_MAX;
	wire hr_wrap = min_wrap && tm_reg[4] == sbh_pkg::MINSEC_MAX;
	wire [15:0] reply_word =
		(ridx_reg == 8'(sbh_pkg::REPLY_ID_WORD)) ? id_reg :
		(ridx_reg == 8'(sbh_pkg::REPLY_NEXT_WORD)) ?
			(id_reg == sbh_pkg::ID_GET_TIME ? next_block_i : sbh_pkg::ID_SET_TIME) :
		(id_reg == sbh_pkg::ID_GET_TIME && ridx_reg >= 8'(sbh_pkg::TIME_FIRST_WORD)
			&& ridx_reg < 8'(sbh_pkg::MS_WORD)) ?
			snap_reg[3'(ridx_reg - 8'(sbh_pkg::TIME_FIRST_WORD))] :
		(id_reg == sbh_pkg::ID_GET_TIME && ridx_reg == 8'(sbh_pkg::MS_WORD)) ? snap_reg[6] :
		16'h0000;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= SBH_IDLE;
			id_reg <= 16'h0000;
			ridx_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				SBH_IDLE: begin
					if (link.wr_valid && link.wr_idx == 8'h00) begin
						id_reg <= link.wr_data;
						state_reg <= link.wr_last ? SBH_IDLE : SBH_RECV;
					end
				end
				SBH_RECV: begin
					if (blk_end) begin
						state_reg <= (do_set || do_get) ? SBH_REPLY : SBH_IDLE;
						ridx_reg <= 8'h00;
					end
				end
				SBH_REPLY: begin
					ridx_reg <= ridx_reg + 8'h01;
					if (ridx_reg == 8'(sbh_pkg::REPLY_ID_WORD))
						state_reg <= SBH_IDLE;
				end
				default: state_reg <= SBH_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 1; i <= 6; i++)
				fld_reg[i] <= 16'h0000;
		end else if (link.wr_valid && state_reg == SBH_RECV
			&& link.wr_idx >= 8'h01 && link.wr_idx <= 8'h06) begin
			fld_reg[3'(link.wr_idx)] <= link.wr_data;
		end
	end

	// Cleared on reset so an unwritten entry reads as no binding, not unknown
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 2 * sbh_pkg::MAP_ENTRIES; i++)
				map_reg[i] <= 64'h0;
		end else if (map_wr) begin
			map_reg[map_wslot][map_lane +: 16] <= link.wr_data;
		end
	end

	// Lookup table that the remote file-number resolver reads
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			map_out_reg <= 64'h0;
		else
			map_out_reg <= map_sel_ok ? map_reg[map_rslot] : 64'h0;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tm_reg[0] <= sbh_pkg::YEAR_RESET;
			tm_reg[1] <= 16'h0001;
			tm_reg[2] <= 16'h0001;
			for (int i = 3; i < 6; i++)
				tm_reg[i] <= 16'h0000;
			ms_reg <= 16'h0000;
			tick_reg <= 32'h0;
		end else if (do_set) begin
			for (int i = 0; i < 6; i++)
				tm_reg[i] <= fld_reg[i + 1];
			ms_reg <= 16'h0000;
			tick_reg <= 32'h0;
		end else begin
			tick_reg <= ms_wrap ? 32'h0 : tick_reg + 32'h1;
			if (ms_wrap)
				ms_reg <= sec_wrap ? 16'h0000 : ms_reg + 16'h0001;
			if (sec_wrap)
				tm_reg[5] <= min_wrap ? 16'h0000 : tm_reg[5] + 16'h0001;
			if (min_wrap)
				tm_reg[4] <= hr_wrap ? 16'h0000 : tm_reg[4] + 16'h0001;
			if (hr_wrap)
				tm_reg[3] <= (tm_reg[3] == sbh_pkg::HOUR_MAX) ? 16'h0000 : tm_reg[3] + 16'h0001;
		end
	end

	// Time frozen at the request so a rollover mid-reply cannot tear the fields
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 7; i++)
				snap_reg[i] <= 16'h0000;
		end else if (do_get) begin
			for (int i = 0; i < 6; i++)
				snap_reg[i] <= tm_reg[i];
			snap_reg[6] <= ms_reg;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 16'h0000;
			rd_idx_reg <= 8'h00;
			rd_last_reg <= 1'b0;
			cold_reg <= 1'b0;
			warm_reg <= 1'b0;
		end else begin
			rd_valid_reg <= state_reg == SBH_REPLY;
			rd_data_reg <= reply_word;
			rd_idx_reg <= ridx_reg;
			rd_last_reg <= state_reg == SBH_REPLY && ridx_reg == 8'(sbh_pkg::REPLY_ID_WORD);
			cold_reg <= blk_end && id_reg == sbh_pkg::ID_COLD;
			warm_reg <= blk_end && id_reg == sbh_pkg::ID_WARM;
		end
	end

	assign link.rd_valid = rd_valid_reg;
	assign link.rd_data = rd_data_reg;
	assign link.rd_idx = rd_idx_reg;
	assign link.rd_last = rd_last_reg;
	assign map_entry_o = map_out_reg;
	assign year_o = tm_reg[0];
	assign month_o = tm_reg[1];
	assign day_o = tm_reg[2];
	assign hour_o = tm_reg[3];
	assign minute_o = tm_reg[4];
	assign second_o = tm_reg[5];
	assign cold_boot_o = cold_reg;
	assign warm_boot_o = warm_reg;
endmodule : sbh_module_end
`default_nettype wire

/* File: core/sbh_host_end.sv */
// Host end: streams one special write block per request, captures replies.
// Assumes the caller holds request fields stable while busy_o is high.
`timescale 1ns/1ps
`default_nettype none
module sbh_host_end (
	input wire logic core_clk_i, // 50 MHz clock
	input wire logic reset_n_i, // async reset, active low
	sbh_link_if.host_end link, // block link
	input wire logic req_i, // send block pulse
	input wire logic [15:0] block_id_i, // block code for word 0
	input wire logic [15:0] word_i, // payload for word req_idx_o
	output logic [7:0] req_idx_o, // payload word being fetched
	output logic busy_o, // block in flight
	output logic [15:0] reply_id_o, // word 249 of last reply
	output logic [15:0] reply_w1_o, // word 1 of last reply
	output logic reply_done_o // reply complete pulse
);
	logic busy_reg;
	logic [7:0] idx_reg;
	logic [15:0] rid_reg;
	logic [15:0] rw1_reg;
	logic done_reg;
	logic wv_reg;
	logic [7:0] widx_reg;
	logic [15:0] wdata_reg;
	logic wlast_reg;

	// Warm and cold boot are sent on the caller's request only
	wire [15:0] out_word = (idx_reg == 8'h00) ? block_id_i : word_i;
	wire at_end = idx_reg == 8'(sbh_pkg::BLK_WORDS - 1);

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_reg <= 1'b0;
			idx_reg <= 8'h00;
			wv_reg <= 1'b0;
			widx_reg <= 8'h00;
			wdata_reg <= 16'h0000;
			wlast_reg <= 1'b0;
		end else begin
			wv_reg <= busy_reg;
			widx_reg <= idx_reg;
			wdata_reg <= out_word;
			wlast_reg <= busy_reg && at_end;
			if (!busy_reg && req_i) begin
				busy_reg <= 1'b1;
				idx_reg <= 8'h00;
			end else if (busy_reg) begin
				idx_reg <= at_end ? 8'h00 : idx_reg + 8'h01;
				busy_reg <= !at_end;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rid_reg <= 16'h0000;
			rw1_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= link.rd_valid && link.rd_last;
			if (link.rd_valid && link.rd_idx == 8'(sbh_pkg::REPLY_NEXT_WORD))
				rw1_reg <= link.rd_data;
			if (link.rd_valid && link.rd_idx == 8'(sbh_pkg::REPLY_ID_WORD))
				rid_reg <= link.rd_data;
		end
	end

	assign link.wr_valid = wv_reg;
	assign link.wr_idx = widx_reg;
	assign link.wr_data = wdata_reg;
	assign link.wr_last = wlast_reg;
	assign req_idx_o = idx_reg;
	assign busy_o = busy_reg;
	assign reply_id_o = rid_reg;
	assign reply_w1_o = rw1_reg;
	assign reply_done_o = done_reg;
endmodule : sbh_host_end
`default_nettype wire

/* File: tb/sbh_props.sv */
// Checker on the block link wires between host end and module end.
// Assumes the host waits for each reply before the next block.
`timescale 1ns/1ps
`default_nettype none
module sbh_props (
	input wire logic core_clk_i, // clock
	input wire logic reset_n_i, // async reset, low
	input wire logic wr_valid, // host word valid
	input wire logic [7:0] wr_idx, // host word index
	input wire logic [15:0] wr_data, // host word
	input wire logic wr_last, // host last word
	input wire logic rd_valid, // reply word valid
	input wire logic [7:0] rd_idx, // reply word index
	input wire logic [15:0] rd_data, // reply word
	input wire logic rd_last // reply last word
);
	logic [15:0] id_reg;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			id_reg <= 16'h0000;
		else if (wr_valid && wr_idx == 8'h00)
			id_reg <= wr_data;
	end
	wire logic get_w = rd_valid && id_reg == sbh_pkg::ID_GET_TIME;
	wire logic set_w = rd_valid && id_reg == sbh_pkg::ID_SET_TIME;
	// Blocks that must never draw a reply
	wire logic quiet = id_reg == sbh_pkg::ID_COLD || id_reg == sbh_pkg::ID_WARM
		|| id_reg == sbh_pkg::ID_MAP_P1 || id_reg == sbh_pkg::ID_MAP_P2;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_set_ack; set_w && rd_last |-> rd_data == sbh_pkg::ID_SET_TIME; endproperty
	a_set_ack: assert property (p_set_ack) else $error("set-time ack word wrong");
	property p_set_w1; set_w && rd_idx == 8'h01 |-> rd_data == sbh_pkg::ID_SET_TIME; endproperty
	a_set_w1: assert property (p_set_w1) else $error("set-time word 1 wrong");
	property p_get_ack; get_w && rd_last |-> rd_idx == 8'hF9 && rd_data == 16'h26F5; endproperty
	a_get_ack: assert property (p_get_ack) else $error("get-time ack wrong");
	property p_get_w0; get_w && rd_idx == 8'h00 |-> rd_data == 16'h0000; endproperty
	a_get_w0: assert property (p_get_w0) else $error("get-time word 0 not zero");
	property p_get_ms; get_w && rd_idx == 8'h08 |-> rd_data <= sbh_pkg::MS_MAX; endproperty
	a_get_ms: assert property (p_get_ms) else $error("milliseconds out of range");
	property p_get_mon; get_w && rd_idx == 8'h03 |-> rd_data inside {[1:12]}; endproperty
	a_get_mon: assert property (p_get_mon) else $error("month out of range");
	property p_get_go; wr_valid && wr_last && id_reg == 16'h26F5 |-> ##2 rd_valid && !rd_idx; endproperty
	a_get_go: assert property (p_get_go) else $error("get-time reply late");
	property p_quiet; wr_valid && wr_last && quiet |=> !rd_valid [*8]; endproperty
	a_quiet: assert property (p_quiet) else $error("reply to boot or map block");
	property p_step; rd_valid && !rd_last |=> rd_valid && rd_idx == $past(rd_idx) + 8'h01; endproperty
	a_step: assert property (p_step) else $error("reply words out of order");
endmodule : sbh_props
`default_nettype wire

/* File: tb/special_block_handler_bench.sv */
// Bench joining host end and module end through the link interface.
// Assumes the package and interface from core/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
module special_block_handler_bench;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic req = 1'b0;
	logic [15:0] bid = 16'h0000;
	logic [15:0] nxt = 16'h0A5A;
	logic [5:0] msel = 6'h00;
	logic mport = 1'b0;
	logic [15:0] pay [0:255];
	logic [15:0] rw [0:255];
	wire logic [7:0] ridx;
	wire logic [15:0] word = pay[ridx];
	wire logic busy, rdone, cold, warm;
	wire logic [15:0] rid, rw1, yr, mo, dy, hr, mi, se;
	wire logic [63:0] ment;
	int miscompares = 0;
	int compares = 0;
	int ndone = 0;
	int ncold = 0;
	int nwarm = 0;
	sbh_link_if link ();
	sbh_module_end #(.MS_CYCLES(5)) u_sbh_module_end (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .link(link), .next_block_i(nxt), .map_sel_i(msel),
		.map_port_i(mport), .map_entry_o(ment), .year_o(yr), .month_o(mo), .day_o(dy),
		.hour_o(hr), .minute_o(mi), .second_o(se), .cold_boot_o(cold), .warm_boot_o(warm));
	sbh_host_end u_sbh_host_end (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.link(link), .req_i(req), .block_id_i(bid), .word_i(word), .req_idx_o(ridx),
		.busy_o(busy), .reply_id_o(rid), .reply_w1_o(rw1), .reply_done_o(rdone));
	sbh_props u_sbh_props (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.wr_valid(link.wr_valid), .wr_idx(link.wr_idx), .wr_data(link.wr_data),
		.wr_last(link.wr_last), .rd_valid(link.rd_valid), .rd_idx(link.rd_idx),
		.rd_data(link.rd_data), .rd_last(link.rd_last));
	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (rdone === 1'b1) ndone++;
		if (cold === 1'b1) ncold++;
		if (warm === 1'b1) nwarm++;
		if (link.rd_valid === 1'b1) rw[link.rd_idx] = link.rd_data;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cnt(input int got, input int exp);
		chk(64'(got), 64'(exp));
	endtask : cnt
	// Waits out the reply window, so a missing reply shows in the counters
	task automatic send(input logic [15:0] id);
		int n;
		@(posedge core_clk_i);
		req <= 1'b1;
		bid <= id;
		@(posedge core_clk_i);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk_i);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 400);
		if (n >= 400) cnt(n, 0);
		repeat (260) @(posedge core_clk_i);
	endtask : send
	task automatic good_time();
		pay[1] = 16'h07E8;
		pay[2] = 16'h000C;
		pay[3] = 16'h001F;
		pay[4] = 16'h0017;
		pay[5] = 16'h003B;
		pay[6] = 16'h0000;
	endtask : good_time
	task automatic t_set();
		int d;
		d = ndone;
		good_time();
		send(sbh_pkg::ID_SET_TIME);
		cnt(ndone - d, 1);
		chk(64'(rid), 64'(sbh_pkg::ID_SET_TIME));
		chk(64'(rw1), 64'(sbh_pkg::ID_SET_TIME));
		chk({yr, mo, dy, hr}, 64'h07E8_000C_001F_0017);
		chk({32'h0, mi, se}, 64'h0000_0000_003B_0000);
	endtask : t_set
	task automatic t_bad();
		int d;
		int bw [6] = '{2, 2, 3, 4, 5, 6};
		logic [15:0] bv [6] = '{16'h000D, 16'h0000, 16'h0020, 16'h0018, 16'h003C, 16'h003C};
		d = ndone;
		for (int i = 0; i < 6; i++) begin
			good_time();
			pay[bw[i]] = bv[i];
			send(sbh_pkg::ID_SET_TIME);
		end
		cnt(ndone - d, 0);
		chk({yr, mo, dy, hr}, 64'h07E8_000C_001F_0017);
		chk({32'h0, mi, se}, 64'h0000_0000_003B_0000);
	endtask : t_bad
	task automatic t_get();
		send(sbh_pkg::ID_GET_TIME);
		chk(64'(rid), 64'(sbh_pkg::ID_GET_TIME));
		chk(64'(rw1), 64'(nxt));
		chk({rw[0], rw[2], rw[3], rw[4]}, 64'h0000_07E8_000C_001F);
		chk({rw[7], rw[5], rw[6], rw[249]}, 64'h0000_0017_003B_26F5);
	endtask : t_get
	// Last second of the day: seconds, minutes and hours all roll over
	task automatic t_roll();
		good_time();
		pay[6] = 16'h003B;
		send(sbh_pkg::ID_SET_TIME);
		repeat (4800) @(posedge core_clk_i);
		#1;
		chk({yr, mo, dy, hr}, 64'h07E8_000C_001F_0000);
		chk({32'h0, mi, se}, 64'h0000_0000_0000_0000);
	endtask : t_roll
	task automatic t_boot();
		int c;
		int w;
		int d;
		c = ncold;
		w = nwarm;
		d = ndone;
		send(sbh_pkg::ID_COLD);
		cnt(ncold - c, 1);
		cnt(nwarm - w, 0);
		send(sbh_pkg::ID_WARM);
		cnt(nwarm - w, 1);
		cnt(ncold - c, 1);
		cnt(ndone - d, 0);
	endtask : t_boot
	task automatic t_map();
		for (int p = 0; p < 2; p++) begin
			for (int k = 1; k < 201; k++) pay[k] = {8'(p), 8'(k)};
			send(p == 0 ? sbh_pkg::ID_MAP_P1 : sbh_pkg::ID_MAP_P2);
		end
		for (int p = 0; p < 2; p++) begin
			for (int e = 0; e < 50; e += 49) begin
				@(posedge core_clk_i);
				msel <= 6'(e);
				mport <= p[0];
				@(posedge core_clk_i);
				#1;
				chk(ment, {8'(p), 8'(4 * e + 4), 8'(p), 8'(4 * e + 3),
					8'(p), 8'(4 * e + 2), 8'(p), 8'(4 * e + 1)});
			end
		end
	endtask : t_map
	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	initial begin
		for (int k = 0; k < 256; k++) pay[k] = 16'h0000;
		repeat (16) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		t_set();
		t_bad();
		t_get();
		t_boot();
		t_map();
		t_roll();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		miscompares++;
		test_done();
	end
endmodule : special_block_handler_bench
`default_nettype wire
